// *** design/ldfs_top.sv ***
// ldfs_top: digital control and fault latching for injector, ignition, relay.
// assumes commands and analog comparator flags arrive as plain logic levels.
// How it works
// - injector output follows command unless protected
// - filtered injector short latches output off
// - injector short raises injector fault flag
// - injector overtemperature forces off, raises fault
// - overvoltage latches injector off until toggle
// - injector open load flagged while off
// - injector shorted load flagged while on
// - injector fault clears on command rising edge
// - ignition high drive on, low drive off
// - ignition overcurrent feedback treated as short
// - ignition short keeps high drive off, low drive on
// - ignition open coil flagged while off
// - overvoltage latches ignition off until edge
// - ignition fault holds until command rising edge
// - relay output follows command unless protected
// - filtered relay short latches off, faults
// - relay overtemperature forces off, raises fault
// - overvoltage latches relay off until toggle
// - relay open load flagged while off
// - relay shorted load flagged while on
// - relay fault holds until command rising edge
// - fault flags rest low after reset
`timescale 1ns/1ns
module ldfs_top
   import ldfs_pkg::*;
#(
   parameter int unsigned FILT_CYC = SHORT_FILT_CYC
)
(
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic injector_command_i,
   input  wire logic ignition_command_i,
   input  wire logic relay_command_i,
   input  wire logic main_supply_ov_i,
   input  wire logic injector_short_i,
   input  wire logic injector_overtemp_i,
   input  wire logic injector_open_i,
   input  wire logic ignition_feedback_sense_over_i,
   input  wire logic ignition_feedback_sense_open_i,
   input  wire logic ignition_overtemp_i,
   input  wire logic relay_short_i,
   input  wire logic relay_overtemp_i,
   input  wire logic relay_open_i,
   output logic      injector_output_o,
   output logic      ignition_high_drive_o,
   output logic      ignition_low_drive_o,
   output logic      relay_output_o,
   output logic      injector_fault_flag_o,
   output logic      ignition_fault_flag_o,
   output logic      relay_fault_flag_o
);

   typedef struct packed {
      logic [N_CH-1:0][1:0]       cmd_s;
      logic [N_CH-1:0]            cmd_prev;
      logic [N_CH-1:0][1:0]       sht_s;
      logic [N_CH-1:0][1:0]       ot_s;
      logic [N_CH-1:0][1:0]       opn_s;
      logic [1:0]                 ov_s;
      logic [N_CH-1:0][CNT_W-1:0] filt;
      logic [N_CH-1:0]            lock;
      logic [N_CH-1:0]            flt;
      logic [N_CH-1:0]            on;
   } ldfs_state_t;

   ldfs_state_t st_r;
   ldfs_state_t st_nxt;

   logic [N_CH-1:0] cmd_raw;
   logic [N_CH-1:0] sht_raw;
   logic [N_CH-1:0] ot_raw;
   logic [N_CH-1:0] opn_raw;

   assign cmd_raw = {relay_command_i, ignition_command_i, injector_command_i};
   assign sht_raw = {relay_short_i, ignition_feedback_sense_over_i, injector_short_i};
   assign ot_raw  = {relay_overtemp_i, ignition_overtemp_i, injector_overtemp_i};
   assign opn_raw = {relay_open_i, ignition_feedback_sense_open_i, injector_open_i};

   function automatic logic [1:0] sync_step(input logic [1:0] s, input logic d);
      sync_step = {s[0], d};
   endfunction

   // next short filter count; restarts when the short drops or the drive is off
   // saturates at the limit so a long short cannot wrap it
   function automatic logic [CNT_W-1:0] filt_step(input logic [CNT_W-1:0] cnt,
                                                  input logic             hit);
      if (!hit)
      begin
         filt_step = CNT_RST;
      end
      else if (cnt < CNT_W'(FILT_CYC))
      begin
         filt_step = cnt + CNT_W'(1);
      end
      else
      begin
         filt_step = cnt;
      end
   endfunction

   // filter expires on the cycle the count would reach its limit
   // one cycle early, so the drive drops right at the limit
   function automatic logic filt_done(input logic [CNT_W-1:0] cnt,
                                      input logic             hit);
      filt_done = hit && (cnt + CNT_W'(1) >= CNT_W'(FILT_CYC));
   endfunction

   // rising edge between two synced samples
   function automatic logic rise_of(input logic cur, input logic prev);
      rise_of = cur && !prev;
   endfunction

   // drive allowed only with no latch, no overtemp, no overvoltage
   // overtemp does not latch: the drive returns once it clears
   function automatic logic drive_ok(input logic cmd,
                                     input logic lock,
                                     input logic hot,
                                     input logic ovv);
      drive_ok = cmd && !lock && !hot && !ovv;
   endfunction

   // second sync stages: the only copies the latch logic may read
   // first stages may still be settling, so nothing else reads them
   logic [N_CH-1:0] cmd_q;
   logic [N_CH-1:0] sht_q;
   logic [N_CH-1:0] ot_q;
   logic [N_CH-1:0] opn_q;
   logic            ov_q;

   always_comb
   begin
      ov_q = st_r.ov_s[1];
      for (int c = 0; c < N_CH; c++)
      begin
         cmd_q[c] = st_r.cmd_s[c][1];
         sht_q[c] = st_r.sht_s[c][1];
         ot_q[c]  = st_r.ot_s[c][1];
         opn_q[c] = st_r.opn_s[c][1];
      end
   end

   // per channel: filter, latch, flag and drive, in that order
   always_comb
   begin
      logic cmd;
      logic rise;
      logic sht;
      logic ot;
      logic opn;
      logic ov;
      logic drv;
      logic filt_hit;
      logic load_short;
      logic open_seen;
      logic unlock_ok;

      // overvoltage is shared by all three channels
      cmd        = 1'b0;
      rise       = 1'b0;
      sht        = 1'b0;
      ot         = 1'b0;
      opn        = 1'b0;
      ov         = ov_q;
      drv        = 1'b0;
      filt_hit   = 1'b0;
      load_short = 1'b0;
      open_seen  = 1'b0;
      unlock_ok  = 1'b0;
      st_nxt     = st_r;

      st_nxt.ov_s = sync_step(st_r.ov_s, main_supply_ov_i);

      for (int c = 0; c < N_CH; c++)
      begin
         st_nxt.cmd_s[c] = sync_step(st_r.cmd_s[c], cmd_raw[c]);
         st_nxt.sht_s[c] = sync_step(st_r.sht_s[c], sht_raw[c]);
         st_nxt.ot_s[c]  = sync_step(st_r.ot_s[c], ot_raw[c]);
         st_nxt.opn_s[c] = sync_step(st_r.opn_s[c], opn_raw[c]);

         cmd = cmd_q[c];
         sht = sht_q[c];
         ot  = ot_q[c];
         opn = opn_q[c];
         drv = st_r.on[c];
         st_nxt.cmd_prev[c] = cmd;
         rise = rise_of(cmd, st_r.cmd_prev[c]);

         st_nxt.filt[c] = filt_step(st_r.filt[c], sht && drv);
         filt_hit       = filt_done(st_r.filt[c], sht && drv);
         load_short     = sht && drv;
         // open load only means something with the drive off
         // open load while off
         open_seen      = opn && !drv;

         // unlock first, so a latch cause in the same cycle wins
         // unlock needs clean toggle
         unlock_ok = rise && !sht && !ov;
         if (unlock_ok)
         begin
            st_nxt.lock[c] = 1'b0;
         end
         if (filt_hit)
         begin
            st_nxt.lock[c] = 1'b1;
         end
         if (ov)
         begin
            st_nxt.lock[c] = 1'b1;
         end

         if (rise)
         begin
            st_nxt.flt[c] = 1'b0;
         end
         // causes follow the clear so a live fault wins
         // short raises flag
         if (filt_hit)
         begin
            st_nxt.flt[c] = 1'b1;
         end
         if (load_short)
         begin
            st_nxt.flt[c] = 1'b1;
         end
         if (ot)
         begin
            st_nxt.flt[c] = 1'b1;
         end
         if (ov)
         begin
            st_nxt.flt[c] = 1'b1;
         end
         if (open_seen)
         begin
            st_nxt.flt[c] = 1'b1;
         end

         st_nxt.on[c] = drive_ok(cmd, st_nxt.lock[c], ot, ov);
      end
      if (rst_i)
      begin
         st_nxt = '0;
      end
   end

   // all outputs and flags low after reset, except ignition low drive, which is high
   always_ff @(posedge ref_clk_i)
   begin
      st_r <= st_nxt;
   end

   assign injector_output_o     = st_r.on[CH_INJ];
   assign ignition_high_drive_o = st_r.on[CH_IGN];
   assign ignition_low_drive_o  = ~st_r.on[CH_IGN];
   assign relay_output_o        = st_r.on[CH_REL];
   assign injector_fault_flag_o = st_r.flt[CH_INJ];
   assign ignition_fault_flag_o = st_r.flt[CH_IGN];
   assign relay_fault_flag_o    = st_r.flt[CH_REL];

endmodule

// *** design/ldfs_pkg.sv ***
// ldfs_pkg: shared constants for the load driver fault supervisor.
// assumes one 100 MHz clock and synchronous active-high reset.
package ldfs_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;
   // short-to-battery filter time in ns, and its cycle count (rounded up)
   localparam int unsigned SHORT_FILT_NS = 100;
   localparam int unsigned SHORT_FILT_CYC =
      (SHORT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [1:0] SYNC_RST = 2'h0;
   localparam logic CH_RST = 1'b0;
   localparam int unsigned N_CH = 3;
   localparam int unsigned CH_INJ = 0;
   localparam int unsigned CH_IGN = 1;
   localparam int unsigned CH_REL = 2;

endpackage

// *** tb/ldfs_checker.sv ***
// ldfs_checker: port assertions for ldfs_top
// assumes bind onto ldfs_top, one clock domain
`timescale 1ns/1ns
module ldfs_checker (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic main_supply_ov_i,
   input wire logic injector_command_i,
   input wire logic ignition_command_i,
   input wire logic relay_command_i,
   input wire logic injector_overtemp_i,
   input wire logic relay_overtemp_i,
   input wire logic injector_output_o,
   input wire logic ignition_high_drive_o,
   input wire logic ignition_low_drive_o,
   input wire logic relay_output_o,
   input wire logic injector_fault_flag_o,
   input wire logic ignition_fault_flag_o,
   input wire logic relay_fault_flag_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ov_held;
      main_supply_ov_i [*4];
   endsequence
   a_inj_on_cmd: assert property (injector_output_o |-> $past(injector_command_i, 3))
      else $error("injector on without command");
   a_rel_on_cmd: assert property (relay_output_o |-> $past(relay_command_i, 3))
      else $error("relay on without command");
   a_ign_drive_pair: assert property (ignition_low_drive_o != ignition_high_drive_o)
      else $error("ignition drives not complementary");
   a_inj_hot_off: assert property (injector_overtemp_i [*4] |->
      !injector_output_o && injector_fault_flag_o) else $error("injector hot but on");
   a_rel_hot_off: assert property (relay_overtemp_i [*4] |->
      !relay_output_o && relay_fault_flag_o) else $error("relay hot but on");
   a_ov_all_off: assert property (s_ov_held |-> !injector_output_o && !relay_output_o
      && !ignition_high_drive_o && injector_fault_flag_o && relay_fault_flag_o)
      else $error("overvoltage left a drive on");
   a_inj_flag_clear: assert property ($fell(injector_fault_flag_o) |->
      $past(injector_command_i, 3) && !$past(injector_command_i, 4))
      else $error("injector flag cleared without edge");
   a_ign_flag_clear: assert property ($fell(ignition_fault_flag_o) |->
      $past(ignition_command_i, 3) && !$past(ignition_command_i, 4))
      else $error("ignition flag cleared without edge");
   a_rel_flag_clear: assert property ($fell(relay_fault_flag_o) |->
      $past(relay_command_i, 3) && !$past(relay_command_i, 4))
      else $error("relay flag cleared without edge");
endmodule
bind ldfs_top ldfs_checker chk (.*);

// *** tb/ldfs_host_model.sv ***
// ldfs_host_model: host side, drives the three commands as levels
// assumes falling-edge updates, requests from the bench
`timescale 1ns/1ns
module ldfs_host_model (
   input  wire logic       ref_clk_i,
   input  wire logic [2:0] want_i,
   output logic      [2:0] cmd_o = 3'h0
);
   always @(negedge ref_clk_i) cmd_o <= want_i;
endmodule

// *** tb/ldfs_top_bench.sv ***
// ldfs_top_bench: directed and random checks of ldfs_top
// assumes host model drives commands, checker bound apart
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ldfs_top_bench;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, look = 1'b0;
   wire logic main_supply_ov_i, injector_short_i, injector_overtemp_i, injector_open_i;
   wire logic ignition_feedback_sense_over_i, ignition_feedback_sense_open_i;
   wire logic ignition_overtemp_i, relay_short_i, relay_overtemp_i, relay_open_i;
   wire logic injector_command_i, ignition_command_i, relay_command_i;
   logic injector_output_o, ignition_high_drive_o, ignition_low_drive_o, relay_output_o;
   logic injector_fault_flag_o, ignition_fault_flag_o, relay_fault_flag_o;
   logic [2:0] want = 3'h0, c;
   logic [9:0] flt = 10'h000;
   logic [6:0] exp_q[$];
   int err_total = 0, n_compared = 0, cyc = 0, seed = 94, i;
   assign {main_supply_ov_i, injector_short_i, injector_overtemp_i, injector_open_i,
      ignition_feedback_sense_over_i, ignition_feedback_sense_open_i, ignition_overtemp_i,
      relay_short_i, relay_overtemp_i, relay_open_i} = flt;
   ldfs_top #(.FILT_CYC(2)) DUT (.*);
   ldfs_host_model host (.ref_clk_i(ref_clk_i), .want_i(want),
      .cmd_o({injector_command_i, ignition_command_i, relay_command_i}));
   always #5 ref_clk_i = ~ref_clk_i;
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic step(input logic [2:0] cm, input logic [9:0] f, input logic [6:0] e);
      want <= cm;
      flt <= f;
      repeat (8) @(negedge ref_clk_i);
      exp_q.push_back(e);
      look <= 1'b1;
      @(negedge ref_clk_i);
      look <= 1'b0;
   endtask
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         err_total++;
         print_verdict();
      end
      if (look) `CHK({injector_output_o, ignition_high_drive_o, ignition_low_drive_o,
         relay_output_o, injector_fault_flag_o, ignition_fault_flag_o,
         relay_fault_flag_o}, exp_q.pop_front())
   end
   initial
   begin
      repeat (16) @(negedge ref_clk_i);
      rst_i = 1'b0;
      step(3'h0, 10'h000, 7'h10);
      step(3'h7, 10'h000, 7'h68);
      step(3'h7, 10'h100, 7'h2C);
      step(3'h7, 10'h000, 7'h2C);
      step(3'h0, 10'h000, 7'h14);
      step(3'h7, 10'h000, 7'h68);
      step(3'h7, 10'h002, 7'h61);
      step(3'h7, 10'h000, 7'h69);
      step(3'h7, 10'h200, 7'h17);
      step(3'h7, 10'h000, 7'h17);
      step(3'h0, 10'h000, 7'h17);
      step(3'h7, 10'h000, 7'h68);
      step(3'h7, 10'h020, 7'h5A);
      step(3'h7, 10'h000, 7'h5A);
      step(3'h0, 10'h051, 7'h17);
      step(3'h7, 10'h000, 7'h68);
      step(3'h7, 10'h080, 7'h2C);
      step(3'h7, 10'h004, 7'h65);
      step(3'h0, 10'h000, 7'h15);
      step(3'h7, 10'h000, 7'h68);
      step(3'h7, 10'h008, 7'h5A);
      step(3'h7, 10'h000, 7'h6A);
      step(3'h0, 10'h000, 7'h12);
      step(3'h7, 10'h000, 7'h68);
      for (i = 0; i < 8; i++)
      begin
         c = 3'($random(seed));
         step(c, 10'h000, {c[2], c[1], ~c[1], c[0], 3'h0});
      end
      print_verdict();
   end
endmodule
